//--- rtl/sob_pkg.sv
// Purpose: Shared constants and types for the scan test octal buffer.
// Assumes: One clock domain; all test pins are sampled by clock_i.
// Notes:   Instruction and boundary-control codes are listed here only.
`default_nettype none
package sob_pkg;

    localparam int IR_LEN  = 8;
    localparam int BSR_LEN = 18;
    localparam int BCR_LEN = 2;
    localparam int GRP_W   = 4;

    // Boundary cell layout: enables, then inputs, then outputs
    localparam int BSR_OE_LSB = 0;
    localparam int BSR_A_LSB  = 2;
    localparam int BSR_Y_LSB  = 10;

    localparam logic [IR_LEN-1:0] IR_EXTEST   = 8'h00;
    localparam logic [IR_LEN-1:0] IR_SAMPLE   = 8'h02;
    localparam logic [IR_LEN-1:0] IR_INTEST   = 8'h03;
    localparam logic [IR_LEN-1:0] IR_CLAMP    = 8'h06;
    localparam logic [IR_LEN-1:0] IR_HIGHZ    = 8'h07;
    localparam logic [IR_LEN-1:0] IR_RUNTEST  = 8'h09;
    localparam logic [IR_LEN-1:0] IR_SELFTEST = 8'h0a;
    localparam logic [IR_LEN-1:0] IR_BCR_SCAN = 8'h0e;
    localparam logic [IR_LEN-1:0] IR_BYPASS   = 8'hff;
    localparam logic [IR_LEN-1:0] IR_STATUS   = 8'h81;

    localparam logic [BCR_LEN-1:0] BCR_TOGGLE                = 2'h0;
    localparam logic [BCR_LEN-1:0] BCR_RANDOM_PATTERN_OUTPUT = 2'h1;
    localparam logic [BCR_LEN-1:0] BCR_SIGNATURE_COMPACTION  = 2'h2;
    localparam logic [BCR_LEN-1:0] BCR_RESET                 = 2'h2;

    localparam logic [2:0] TLR_TMS_HIGHS = 3'h5;
    localparam logic [2:0] CNT_MAX       = 3'h7;

    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } sob_tap_t;

    typedef enum logic [2:0] {
        DR_BYP = 3'h1,
        DR_BSR = 3'h2,
        DR_BCR = 3'h4
    } sob_dr_t;

    typedef enum logic [3:0] {
        PM_NORMAL   = 4'h1,
        PM_DRIVE    = 4'h2,
        PM_INTERNAL = 4'h4,
        PM_FLOAT    = 4'h8
    } sob_pin_t;

endpackage
`default_nettype wire

//--- rtl/sob_scan_buffer.sv
// Purpose: Octal three-state buffer with boundary-scan test logic.
// Assumes: clock_i far faster than tck_i; test pins pass two flip-flops.
// Notes:   Outputs lag pins by three clocks; TAP edges found by sampling.
// Contract
// R1 - Enable high floats output, low passes input
// R2 - Two enables, each gating four outputs
// R3 - Scanning in normal mode leaves buffers intact
// R4 - Test mode: cells observe inputs, drive outputs
// R5 - Sample on tck rise, change on fall
// R6 - TAP state steps on tms at rise
// R7 - Double-high tms forces test reset
// R8 - Shift tdi to tdo via IR or DR
// R9 - Tdo undriven unless shifting
// R10 - Instruction register is eight bits
// R11 - Eighteen-cell boundary, two-bit control, one-bit bypass
// R12 - Signature compaction and random pattern operations
// R13 - Decode standard plus intest, clamp, highz
// R14 - Sample and self test in normal mode
// R15 - Reset loads all-ones IR, control 10
// R16 - IR capture loads status 10000001
// R17 - Five tms highs reach reset state
// R18 - Control operations run only in idle
`timescale 1ns/1ps
`default_nettype none
module sob_scan_buffer (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       tck_i,
    input  wire logic       tms_i,
    input  wire logic       tdi_i,
    input  wire logic       tms_double_high_i,
    input  wire logic       group1_output_enable_n_i,
    input  wire logic       group2_output_enable_n_i,
    input  wire logic [3:0] group1_data_in_i,
    input  wire logic [3:0] group2_data_in_i,
    output logic      [3:0] group1_data_out_o,
    output logic            group1_data_out_oe_n_o,
    output logic      [3:0] group2_data_out_o,
    output logic            group2_data_out_oe_n_o,
    output logic            tdo_o,
    output logic            tdo_oe_n_o
);
    localparam int N = 2 * sob_pkg::GRP_W;

    logic                          tck_m_r, tck_r, tck_d_r;
    logic                          tms_m_r, tms_r, tdi_m_r, tdi_r;
    logic                          dh_m_r, dh_r;
    logic [1:0]                    oe_m_r, oe_n_s_r;
    logic [N-1:0]                  din_m_r, din_s_r;
    logic                          tck_rise, tck_fall;
    sob_pkg::sob_tap_t             state_r;
    logic [sob_pkg::IR_LEN-1:0]    ir_shift_r, ir_r;
    logic [sob_pkg::BSR_LEN-1:0]   bsr_shift_r, bsr_upd_r;
    logic [sob_pkg::BCR_LEN-1:0]   bcr_shift_r, bcr_r;
    logic                          byp_r;
    logic                          tdo_r, tdo_oe_n_r;
    logic [N-1:0]                  out_r;
    logic [1:0]                    oe_n_r;
    logic                          sel_lsb;
    sob_pkg::sob_dr_t              dr_sel;
    sob_pkg::sob_pin_t             pin_mode;
    logic [2:0]                    tms_hi_cnt_r;

    function automatic sob_pkg::sob_tap_t tap_next(
        input sob_pkg::sob_tap_t s, input logic m);
        case (s)
            sob_pkg::ST_RESET:    tap_next = m ? sob_pkg::ST_RESET
                                               : sob_pkg::ST_IDLE;
            sob_pkg::ST_IDLE:     tap_next = m ? sob_pkg::ST_SEL_DR
                                               : sob_pkg::ST_IDLE;
            sob_pkg::ST_SEL_DR:   tap_next = m ? sob_pkg::ST_SEL_IR
                                               : sob_pkg::ST_CAP_DR;
            sob_pkg::ST_CAP_DR:   tap_next = m ? sob_pkg::ST_EXIT1_DR
                                               : sob_pkg::ST_SHIFT_DR;
            sob_pkg::ST_SHIFT_DR: tap_next = m ? sob_pkg::ST_EXIT1_DR
                                               : sob_pkg::ST_SHIFT_DR;
            sob_pkg::ST_EXIT1_DR: tap_next = m ? sob_pkg::ST_UPD_DR
                                               : sob_pkg::ST_PAUSE_DR;
            sob_pkg::ST_PAUSE_DR: tap_next = m ? sob_pkg::ST_EXIT2_DR
                                               : sob_pkg::ST_PAUSE_DR;
            sob_pkg::ST_EXIT2_DR: tap_next = m ? sob_pkg::ST_UPD_DR
                                               : sob_pkg::ST_SHIFT_DR;
            sob_pkg::ST_UPD_DR:   tap_next = m ? sob_pkg::ST_SEL_DR
                                               : sob_pkg::ST_IDLE;
            sob_pkg::ST_SEL_IR:   tap_next = m ? sob_pkg::ST_RESET
                                               : sob_pkg::ST_CAP_IR;
            sob_pkg::ST_CAP_IR:   tap_next = m ? sob_pkg::ST_EXIT1_IR
                                               : sob_pkg::ST_SHIFT_IR;
            sob_pkg::ST_SHIFT_IR: tap_next = m ? sob_pkg::ST_EXIT1_IR
                                               : sob_pkg::ST_SHIFT_IR;
            sob_pkg::ST_EXIT1_IR: tap_next = m ? sob_pkg::ST_UPD_IR
                                               : sob_pkg::ST_PAUSE_IR;
            sob_pkg::ST_PAUSE_IR: tap_next = m ? sob_pkg::ST_EXIT2_IR
                                               : sob_pkg::ST_PAUSE_IR;
            sob_pkg::ST_EXIT2_IR: tap_next = m ? sob_pkg::ST_UPD_IR
                                               : sob_pkg::ST_SHIFT_IR;
            sob_pkg::ST_UPD_IR:   tap_next = m ? sob_pkg::ST_SEL_DR
                                               : sob_pkg::ST_IDLE;
            default:              tap_next = sob_pkg::ST_RESET;
        endcase
    endfunction

    // R13 instruction decode
    function automatic sob_pkg::sob_dr_t ir_dr(
        input logic [sob_pkg::IR_LEN-1:0] ir);
        case (ir)
            sob_pkg::IR_EXTEST, sob_pkg::IR_SAMPLE, sob_pkg::IR_INTEST,
            sob_pkg::IR_RUNTEST, sob_pkg::IR_SELFTEST:
                ir_dr = sob_pkg::DR_BSR;
            sob_pkg::IR_BCR_SCAN: ir_dr = sob_pkg::DR_BCR;
            default:              ir_dr = sob_pkg::DR_BYP;
        endcase
    endfunction

    function automatic sob_pkg::sob_pin_t ir_pin_mode(
        input logic [sob_pkg::IR_LEN-1:0] ir);
        case (ir)
            sob_pkg::IR_EXTEST, sob_pkg::IR_CLAMP, sob_pkg::IR_RUNTEST:
                ir_pin_mode = sob_pkg::PM_DRIVE;
            sob_pkg::IR_INTEST: ir_pin_mode = sob_pkg::PM_INTERNAL;
            sob_pkg::IR_HIGHZ:  ir_pin_mode = sob_pkg::PM_FLOAT;
            default:            ir_pin_mode = sob_pkg::PM_NORMAL;
        endcase
    endfunction

    function automatic logic [N-1:0] lfsr_step(input logic [N-1:0] x);
        lfsr_step = {x[N-2:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // Pins from outside pass two flops before any logic reads them
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            {tck_m_r, tck_r, tck_d_r} <= 3'h7;
            {tms_m_r, tms_r, tdi_m_r, tdi_r} <= 4'hf;
            {dh_m_r, dh_r} <= 2'h0;
            oe_m_r   <= 2'h3;
            oe_n_s_r <= 2'h3;
            din_m_r  <= 8'hff;
            din_s_r  <= 8'hff;
        end else begin
            tck_m_r  <= tck_i;
            tck_r    <= tck_m_r;
            tck_d_r  <= tck_r;
            tms_m_r  <= tms_i;
            tms_r    <= tms_m_r;
            tdi_m_r  <= tdi_i;
            tdi_r    <= tdi_m_r;
            dh_m_r   <= tms_double_high_i;
            dh_r     <= dh_m_r;
            oe_m_r   <= {group2_output_enable_n_i, group1_output_enable_n_i};
            oe_n_s_r <= oe_m_r;
            din_m_r  <= {group2_data_in_i, group1_data_in_i};
            din_s_r  <= din_m_r;
        end
    end

    assign tck_rise = tck_r & ~tck_d_r;
    assign tck_fall = ~tck_r & tck_d_r;
    assign dr_sel   = ir_dr(ir_r);
    assign pin_mode = ir_pin_mode(ir_r);

    // R6 step on rise; R7 double-high acts without tck edges
    always_ff @(posedge clock_i) begin
        if (rst_i || dh_r) begin
            state_r <= sob_pkg::ST_RESET;
        end else if (tck_rise) begin
            state_r <= tap_next(state_r, tms_r);
        end
    end

    // R10 eight-bit instruction path
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ir_shift_r <= sob_pkg::IR_BYPASS;
            ir_r       <= sob_pkg::IR_BYPASS;
        end else begin
            if (tck_rise && state_r == sob_pkg::ST_CAP_IR) begin
                // R16 fixed status
                ir_shift_r <= sob_pkg::IR_STATUS;
            end else if (tck_rise && state_r == sob_pkg::ST_SHIFT_IR) begin
                ir_shift_r <= {tdi_r, ir_shift_r[sob_pkg::IR_LEN-1:1]};
            end
            // R15 reset selects bypass
            if (state_r == sob_pkg::ST_RESET) begin
                ir_r <= sob_pkg::IR_BYPASS;
            end else if (tck_fall && state_r == sob_pkg::ST_UPD_IR) begin
                ir_r <= ir_shift_r;
            end
        end
    end

    // R11 data shift registers; R14 capture snapshots the pins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bsr_shift_r <= '0;
            bcr_shift_r <= sob_pkg::BCR_RESET;
            byp_r       <= 1'b0;
        end else if (tck_rise && state_r == sob_pkg::ST_CAP_DR) begin
            bsr_shift_r <= {out_r, din_s_r, oe_n_s_r};
            bcr_shift_r <= bcr_r;
            byp_r       <= 1'b0;
        end else if (tck_rise && state_r == sob_pkg::ST_SHIFT_DR) begin
            // R8 serial path through selected register
            case (dr_sel)
                sob_pkg::DR_BSR: bsr_shift_r <=
                    {tdi_r, bsr_shift_r[sob_pkg::BSR_LEN-1:1]};
                sob_pkg::DR_BCR: bcr_shift_r <=
                    {tdi_r, bcr_shift_r[sob_pkg::BCR_LEN-1:1]};
                default:         byp_r <= tdi_r;
            endcase
        end
    end

    // Shadow cells change on tck fall only; control register also reloads in reset state
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bsr_upd_r <= '0;
            bcr_r     <= sob_pkg::BCR_RESET;
        end else if (state_r == sob_pkg::ST_RESET) begin
            // R15 control reset to compaction
            bcr_r <= sob_pkg::BCR_RESET;
        end else if (tck_fall && state_r == sob_pkg::ST_UPD_DR) begin
            if (dr_sel == sob_pkg::DR_BSR) begin
                bsr_upd_r <= bsr_shift_r;
            end
            if (dr_sel == sob_pkg::DR_BCR) begin
                bcr_r <= bcr_shift_r;
            end
        end else if (tck_fall && state_r == sob_pkg::ST_IDLE &&
                     (ir_r == sob_pkg::IR_RUNTEST ||
                      ir_r == sob_pkg::IR_SELFTEST)) begin
            // R18 idle-only operations; R12 compaction and patterns
            case (bcr_r)
                sob_pkg::BCR_SIGNATURE_COMPACTION: begin
                    bsr_upd_r[sob_pkg::BSR_A_LSB +: N] <= din_s_r ^
                        lfsr_step(bsr_upd_r[sob_pkg::BSR_A_LSB +: N]);
                end
                sob_pkg::BCR_RANDOM_PATTERN_OUTPUT: begin
                    bsr_upd_r[sob_pkg::BSR_Y_LSB +: N] <=
                        lfsr_step(bsr_upd_r[sob_pkg::BSR_Y_LSB +: N]);
                end
                sob_pkg::BCR_TOGGLE: begin
                    bsr_upd_r[sob_pkg::BSR_Y_LSB +: N] <=
                        ~bsr_upd_r[sob_pkg::BSR_Y_LSB +: N];
                    bsr_upd_r[sob_pkg::BSR_A_LSB +: N] <= din_s_r;
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        case (dr_sel)
            sob_pkg::DR_BSR: sel_lsb = bsr_shift_r[0];
            sob_pkg::DR_BCR: sel_lsb = bcr_shift_r[0];
            default:         sel_lsb = byp_r;
        endcase
    end

    // R5 tdo moves on fall; R9 floats outside shift states
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tdo_r      <= 1'b1;
            tdo_oe_n_r <= 1'b1;
        end else if (tck_fall) begin
            if (state_r == sob_pkg::ST_SHIFT_IR) begin
                tdo_r      <= ir_shift_r[0];
                tdo_oe_n_r <= 1'b0;
            end else if (state_r == sob_pkg::ST_SHIFT_DR) begin
                tdo_r      <= sel_lsb;
                tdo_oe_n_r <= 1'b0;
            end else begin
                tdo_oe_n_r <= 1'b1;
            end
        end
    end

    // R1 R2 R3 buffer path; R4 R13 cells take over in test mode
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_r  <= '0;
            oe_n_r <= 2'h3;
        end else begin
            case (pin_mode)
                sob_pkg::PM_DRIVE: begin
                    out_r  <= bsr_upd_r[sob_pkg::BSR_Y_LSB +: N];
                    oe_n_r <= bsr_upd_r[sob_pkg::BSR_OE_LSB +: 2];
                end
                sob_pkg::PM_INTERNAL: begin
                    out_r  <= bsr_upd_r[sob_pkg::BSR_A_LSB +: N];
                    oe_n_r <= bsr_upd_r[sob_pkg::BSR_OE_LSB +: 2];
                end
                sob_pkg::PM_FLOAT: oe_n_r <= 2'h3;
                default: begin
                    out_r  <= din_s_r;
                    oe_n_r <= oe_n_s_r;
                end
            endcase
        end
    end

    assign group1_data_out_o      = out_r[sob_pkg::GRP_W-1:0];
    assign group2_data_out_o      = out_r[N-1:sob_pkg::GRP_W];
    assign group1_data_out_oe_n_o = oe_n_r[0];
    assign group2_data_out_oe_n_o = oe_n_r[1];
    assign tdo_o                  = tdo_r;
    assign tdo_oe_n_o             = tdo_oe_n_r;

    // Counts consecutive tms-high rises for checking only
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tms_hi_cnt_r <= '0;
        end else if (tck_rise) begin
            tms_hi_cnt_r <= !tms_r ? 3'h0 :
                (tms_hi_cnt_r == sob_pkg::CNT_MAX) ? tms_hi_cnt_r :
                3'(tms_hi_cnt_r + 3'h1);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_state_on_rise: assert property ( // R6
        !tck_rise && !dh_r |=> $stable(state_r))
        else $error("tap state moved without tck rise");
    a_double_high_reset: assert property ( // R7
        dh_r |=> state_r == sob_pkg::ST_RESET)
        else $error("double-high tms did not reset");
    a_tms_five_reset: assert property ( // R17
        tms_hi_cnt_r >= sob_pkg::TLR_TMS_HIGHS
            |-> state_r == sob_pkg::ST_RESET)
        else $error("five tms highs missed reset");
    a_reset_loads_ir: assert property ( // R15
        state_r == sob_pkg::ST_RESET |=> ir_r == sob_pkg::IR_BYPASS
            && bcr_r == sob_pkg::BCR_RESET)
        else $error("reset values not loaded");
    a_capture_ir_status: assert property ( // R16
        tck_rise && state_r == sob_pkg::ST_CAP_IR
            |=> ir_shift_r == sob_pkg::IR_STATUS)
        else $error("ir capture value wrong");
    a_tdo_on_fall: assert property ( // R5
        !tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_n_o))
        else $error("tdo changed off tck fall");
    a_tdo_shift_data: assert property ( // R8
        tck_fall && state_r == sob_pkg::ST_SHIFT_DR
            |=> !tdo_oe_n_o && tdo_o == $past(sel_lsb))
        else $error("tdo not driving selected lsb");
    a_tdo_idle_float: assert property ( // R9
        tck_fall && state_r != sob_pkg::ST_SHIFT_DR
            && state_r != sob_pkg::ST_SHIFT_IR |=> tdo_oe_n_o)
        else $error("tdo driven outside shift");
    a_normal_buffer: assert property ( // R1
        pin_mode == sob_pkg::PM_NORMAL
            |=> {group2_data_out_o, group1_data_out_o} == $past(din_s_r)
            && {group2_data_out_oe_n_o, group1_data_out_oe_n_o}
               == $past(oe_n_s_r))
        else $error("normal buffer path broken");
    a_test_drive_cells: assert property ( // R4
        pin_mode == sob_pkg::PM_DRIVE
            |=> {group2_data_out_o, group1_data_out_o}
                == $past(bsr_upd_r[sob_pkg::BSR_Y_LSB +: N]))
        else $error("outputs not from boundary cells");
    a_highz_float: assert property ( // R13
        pin_mode == sob_pkg::PM_FLOAT
            |=> group1_data_out_oe_n_o && group2_data_out_oe_n_o)
        else $error("highz left outputs driven");
    a_compaction_step: assert property ( // R12
        tck_fall && state_r == sob_pkg::ST_IDLE
            && (ir_r == sob_pkg::IR_RUNTEST || ir_r == sob_pkg::IR_SELFTEST)
            && bcr_r == sob_pkg::BCR_SIGNATURE_COMPACTION
            |=> bsr_upd_r[sob_pkg::BSR_A_LSB +: N] ==
                (lfsr_step($past(bsr_upd_r[sob_pkg::BSR_A_LSB +: N]))
                 ^ $past(din_s_r)))
        else $error("signature step wrong");
    a_ops_idle_only: assert property ( // R18
        !(tck_fall && (state_r == sob_pkg::ST_IDLE
            || state_r == sob_pkg::ST_UPD_DR)) |=> $stable(bsr_upd_r))
        else $error("cells changed outside idle or update");

    c_update_ir: cover property (tck_fall && state_r == sob_pkg::ST_UPD_IR);
    c_shift_dr: cover property (tck_rise && state_r == sob_pkg::ST_SHIFT_DR);
    c_pattern_run: cover property (tck_fall && state_r == sob_pkg::ST_IDLE
        && ir_r == sob_pkg::IR_RUNTEST
        && bcr_r == sob_pkg::BCR_RANDOM_PATTERN_OUTPUT);
    c_highz: cover property (pin_mode == sob_pkg::PM_FLOAT);

endmodule
`default_nettype wire

//--- tb/sob_scan_master.sv
// Purpose: Board-side scan controller model driving the TAP pins.
// Assumes: tck idles high between frames; the tdo line has a pull-up.
// Notes:   One tck period is 8 clocks: 5 low, 3 high, low half first.
`timescale 1ns/1ps
`default_nettype none
module sob_scan_master (
    input  wire logic clock_i,
    input  wire logic tdo_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      double_high_o
);
    initial begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        double_high_o = 1'b0;
    end

    // steer on fall, sample tdo before rise
    task automatic tck_cycle(input logic tms, input logic tdi,
                             output logic tdo);
        @(posedge clock_i);
        tms_o <= tms;
        tdi_o <= tdi;
        tck_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        // Late sample: the device may need three clocks to move tdo
        @(negedge clock_i);
        tdo = tdo_i;
        @(posedge clock_i);
        tck_o <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    // scan walk from idle back to idle, lsb first
    task automatic scan(input logic is_ir, input int len,
                        input logic [31:0] din, output logic [31:0] dout);
        logic b;
        tck_cycle(1'b1, 1'b1, b);
        if (is_ir) tck_cycle(1'b1, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
        dout = '0;
        for (int i = 0; i < len; i++) begin
            tck_cycle(i == len - 1, din[i], b);
            dout[i] = b;
        end
        tck_cycle(1'b1, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
    endtask

    // tms ones reach reset, then a zero to idle
    task automatic reset_walk(input int n);
        logic b;
        repeat (n) tck_cycle(1'b1, 1'b1, b);
        tck_cycle(1'b0, 1'b1, b);
    endtask

    // double-high level resets with tck standing still
    task automatic test_reset();
        @(posedge clock_i);
        double_high_o <= 1'b1;
        repeat (4) @(posedge clock_i);
        double_high_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/test_scan_test_octal_buffer.sv
// Purpose: Self-checking bench for the scan test octal buffer.
// Assumes: Scan controller model drives the TAP; tdo has a pull-up.
// Notes:   Pin model covers normal, drive, internal and float modes.
`timescale 1ns/1ps
`default_nettype none
module test_scan_test_octal_buffer;
    logic        clock_i, rst_i, oe1_n, oe2_n, y1_oe_n, y2_oe_n;
    logic        tck, tms, tdi, dbl_hi, tdo, tdo_oe_n, bit_seen;
    logic [3:0]  a1, a2, y1, y2;
    wire logic   tdo_line;
    int          n_fail, checks_done, seed;
    logic [7:0]  m_ir, sig;
    logic [17:0] m_shadow;
    logic [31:0] got;
    logic [7:0]  codes [$];

    assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

    sob_scan_buffer sob_scan_buffer_inst (
        .clock_i(clock_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tms_double_high_i(dbl_hi),
        .group1_output_enable_n_i(oe1_n), .group2_output_enable_n_i(oe2_n),
        .group1_data_in_i(a1), .group2_data_in_i(a2),
        .group1_data_out_o(y1), .group1_data_out_oe_n_o(y1_oe_n),
        .group2_data_out_o(y2), .group2_data_out_oe_n_o(y2_oe_n),
        .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n));

    sob_scan_master sob_scan_master_inst (
        .clock_i(clock_i), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi), .double_high_o(dbl_hi));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic print_verdict();
        $display("checks_done %0d n_fail %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Cell register step: taps 7, 5, 4 and 3 feed bit 0
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], ^(x & 8'hb8)};
    endfunction

    // Pin model: floating outputs carry no data worth comparing
    task automatic chk_pins();
        logic [1:0] eo;
        logic [7:0] ey;
        repeat (5) @(posedge clock_i);
        @(negedge clock_i);
        eo = {oe2_n, oe1_n};
        ey = {a2, a1};
        case (m_ir)
            sob_pkg::IR_EXTEST, sob_pkg::IR_CLAMP, sob_pkg::IR_RUNTEST: begin
                eo = m_shadow[1:0];
                ey = m_shadow[17:10];
            end
            sob_pkg::IR_INTEST: begin
                eo = m_shadow[1:0];
                ey = m_shadow[9:2];
            end
            sob_pkg::IR_HIGHZ: eo = 2'h3;
            default: ;
        endcase
        chk_val("enables", {30'h0, eo}, {30'h0, y2_oe_n, y1_oe_n});
        if (eo[0] === 1'b0) chk_val("group1", {28'h0, ey[3:0]}, {28'h0, y1});
        if (eo[1] === 1'b0) chk_val("group2", {28'h0, ey[7:4]}, {28'h0, y2});
    endtask

    task automatic set_pins(input logic on);
        logic [9:0] r;
        r = 10'($random(seed));
        @(posedge clock_i);
        oe1_n <= r[0] & ~on;
        oe2_n <= r[1] & ~on;
        a1 <= r[5:2];
        a2 <= r[9:6];
    endtask

    initial begin
        repeat (50000) @(posedge clock_i);
        n_fail++;
        $display("FAIL watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        {n_fail, checks_done} = 0;
        seed = 32'h2ffe5eb4;
        {rst_i, oe1_n, oe2_n, a1, a2} = 11'h7ff;
        m_ir = sob_pkg::IR_BYPASS;
        m_shadow = '0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        chk_val("tdo_float", 32'h1, {31'h0, tdo_oe_n});
        sob_scan_master_inst.reset_walk(0);
        for (int i = 0; i < 8; i++) begin
            set_pins(1'b0);
            chk_pins();
        end
        $display("test buffer done");
        set_pins(1'b0);
        sob_scan_master_inst.scan(1'b0, 4, 32'hb, got);
        chk_val("bypass", 32'h6, got);
        chk_pins();
        chk_val("tdo_idle", 32'h1, {31'h0, tdo_line});
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_BCR_SCAN), got);
        chk_val("ir_capture", 32'h81, got);
        m_ir = sob_pkg::IR_BCR_SCAN;
        sob_scan_master_inst.scan(1'b0, 2, 32'h1, got);
        chk_val("control_reset", 32'h2, got);
        sob_scan_master_inst.scan(1'b0, 2, 32'h2, got);
        chk_val("control_update", 32'h1, got);
        chk_pins();
        $display("test registers done");
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_SAMPLE), got);
        m_ir = sob_pkg::IR_SAMPLE;
        set_pins(1'b1);
        chk_pins();
        m_shadow = 18'($random(seed));
        sob_scan_master_inst.scan(1'b0, 18, {14'h0, m_shadow}, got);
        chk_val("sample", {14'h0, a2, a1, a2, a1, 2'h0}, got);
        codes = '{sob_pkg::IR_EXTEST, sob_pkg::IR_INTEST, sob_pkg::IR_HIGHZ,
                  sob_pkg::IR_CLAMP};
        foreach (codes[i]) begin
            sob_scan_master_inst.scan(1'b1, 8, {24'h0, codes[i]}, got);
            chk_val("ir_capture", 32'h81, got);
            m_ir = codes[i];
            set_pins(1'b0);
            chk_pins();
        end
        sob_scan_master_inst.scan(1'b0, 2, 32'h1, got);
        chk_val("clamp_bypass", 32'h2, got);
        $display("test modes done");
        sob_scan_master_inst.reset_walk(5);
        m_ir = sob_pkg::IR_BYPASS;
        chk_pins();
        sob_scan_master_inst.scan(1'b1, 8, 32'h0, got);
        m_ir = sob_pkg::IR_EXTEST;
        sob_scan_master_inst.test_reset();
        m_ir = sob_pkg::IR_BYPASS;
        chk_pins();
        sob_scan_master_inst.reset_walk(0);
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_SELFTEST), got);
        m_ir = sob_pkg::IR_SELFTEST;
        set_pins(1'b0);
        repeat (4) sob_scan_master_inst.tck_cycle(1'b0, 1'b1, bit_seen);
        chk_pins();
        $display("test resets done");
        // Four idle falls plus the one that starts the next scan
        sig = m_shadow[9:2];
        repeat (5) sig = lfsr(sig) ^ {a2, a1};
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_INTEST), got);
        m_ir = sob_pkg::IR_INTEST;
        @(negedge clock_i);
        chk_val("signature", {24'h0, sig}, {24'h0, y2, y1});
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_BCR_SCAN), got);
        sob_scan_master_inst.scan(1'b0, 2, 32'h1, got);
        chk_val("control_after_reset", 32'h2, got);
        sob_scan_master_inst.scan(1'b1, 8, 32'(sob_pkg::IR_RUNTEST), got);
        m_ir = sob_pkg::IR_RUNTEST;
        repeat (3) sob_scan_master_inst.tck_cycle(1'b0, 1'b1, bit_seen);
        repeat (3) m_shadow[17:10] = lfsr(m_shadow[17:10]);
        chk_pins();
        chk_val("pattern", {24'h0, m_shadow[17:10]}, {24'h0, y2, y1});
        $display("test operations done");
        print_verdict();
    end
endmodule
`default_nettype wire
